// >>> scps_controller.sv
`timescale 1ns/1ps
module scps_controller (
   // System
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Link to device
   scps_link_if.ctrl        link,
   // User requests
   input  wire logic        reqValid,
   input  wire logic [3:0]  reqCmd,
   input  wire logic [2:0]  reqBank,
   input  wire logic [13:0] reqAddr,
   input  wire logic        reqOdt,
   input  wire logic        pdReq,
   input  wire logic        srReq,
   // User status
   output logic             reqTaken,
   output logic [1:0]       lowPowerMode
);

   typedef enum logic [1:0] {
      C_RUN = 2'b00,
      C_PD  = 2'b01,
      C_SR  = 2'b10
   } scps_cstate_t;

   scps_cstate_t                     state_r;
   scps_pkg::scps_cmd_t              ucmd;
   logic                             cke_r;
   logic [3:0]                       pins_r;
   logic [2:0]                       bank_r;
   logic [13:0]                      addr_r;
   logic                             odt_r;
   logic                             taken_r;
   logic [scps_pkg::BANKS-1:0]       open_r;
   logic [9:0]                       mrsCnt_r;
   logic [9:0]                       holdCnt_r;
   logic [9:0]                       exitCnt_r;
   logic [9:0]                       lockCnt_r;
   logic [9:0]                       wrCnt_r;
   logic [9:0]                       burstCnt_r;
   logic                             ok;

   assign ucmd = scps_pkg::scps_cmd_t'(reqCmd);

   // Command allowed now
   always_comb begin
      ok = (exitCnt_r == '0);
      if (ucmd == scps_pkg::CMD_RD && lockCnt_r != '0) ok = 1'b0;
      if (ucmd == scps_pkg::CMD_WR && wrCnt_r != '0) ok = 1'b0;
      if (ucmd == scps_pkg::CMD_REF && open_r != '0) ok = 1'b0;
   end

   // Sequencer driving the pins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r   <= C_RUN;
         cke_r     <= 1'b1;
         pins_r    <= scps_pkg::CMD_NOP;
         bank_r    <= '0;
         addr_r    <= '0;
         taken_r   <= 1'b0;
         open_r    <= '0;
         holdCnt_r <= '0;
         exitCnt_r <= '0;
         lockCnt_r <= '0;
         wrCnt_r   <= '0;
         mrsCnt_r  <= '0;
         burstCnt_r <= '0;
      end else begin
         pins_r     <= scps_pkg::CMD_NOP;
         taken_r    <= 1'b0;
         holdCnt_r  <= scps_pkg::decCnt(holdCnt_r);
         exitCnt_r  <= scps_pkg::decCnt(exitCnt_r);
         lockCnt_r  <= scps_pkg::decCnt(lockCnt_r);
         wrCnt_r    <= scps_pkg::decCnt(wrCnt_r);
         mrsCnt_r   <= scps_pkg::decCnt(mrsCnt_r);
         burstCnt_r <= scps_pkg::decCnt(burstCnt_r);
         case (state_r)
            C_RUN: begin
               if ((srReq || pdReq) && mrsCnt_r == '0 && holdCnt_r == '0
                   && exitCnt_r == '0) begin
                  if (srReq && burstCnt_r == '0 && open_r == '0 && lockCnt_r == '0) begin
                     cke_r     <= 1'b0;
                     pins_r    <= scps_pkg::CMD_REF;
                     holdCnt_r <= scps_pkg::CKE_MIN_PULSE_TIME - 10'h001;
                     state_r   <= C_SR;
                  end else if (!srReq) begin
                     cke_r     <= 1'b0;
                     holdCnt_r <= scps_pkg::CKE_MIN_PULSE_TIME - 10'h001;
                     state_r   <= C_PD;
                  end
               end else if (reqValid && ok) begin
                  pins_r  <= reqCmd;
                  bank_r  <= reqBank;
                  addr_r  <= reqAddr;
                  taken_r <= 1'b1;
                  if (ucmd == scps_pkg::CMD_ACT) open_r[reqBank] <= 1'b1;
                  if (ucmd == scps_pkg::CMD_PRE) begin
                     if (reqAddr[scps_pkg::AP_BIT]) open_r <= '0;
                     else open_r[reqBank] <= 1'b0;
                  end
                  if ((ucmd == scps_pkg::CMD_RD || ucmd == scps_pkg::CMD_WR)
                      && reqAddr[scps_pkg::AP_BIT]) open_r[reqBank] <= 1'b0;
                  if (ucmd == scps_pkg::CMD_RD || ucmd == scps_pkg::CMD_WR)
                     burstCnt_r <= scps_pkg::BURST_CYCLES;
                  if (ucmd == scps_pkg::CMD_MRS)
                     mrsCnt_r <= scps_pkg::maxCnt(scps_pkg::MODE_SET_CMD_GAP,
                                                  scps_pkg::MODE_SET_UPDATE_DELAY);
               end
            end
            C_PD: begin
               if (!pdReq && holdCnt_r == '0) begin
                  cke_r     <= 1'b1;
                  holdCnt_r <= scps_pkg::CKE_MIN_PULSE_TIME - 10'h001;
                  exitCnt_r <= scps_pkg::POWERDOWN_EXIT_DELAY;
                  lockCnt_r <= scps_pkg::POWERDOWN_EXIT_LOCK_DELAY;
                  state_r   <= C_RUN;
               end
            end
            C_SR: begin
               if (!srReq && holdCnt_r == '0) begin
                  cke_r     <= 1'b1;
                  holdCnt_r <= scps_pkg::CKE_MIN_PULSE_TIME - 10'h001;
                  exitCnt_r <= scps_pkg::SELFREF_EXIT_DELAY;
                  lockCnt_r <= scps_pkg::SELFREF_EXIT_LOCK_DELAY;
                  wrCnt_r   <= scps_pkg::SELFREF_WRITE_HOLDOFF;
                  state_r   <= C_RUN;
               end
            end
            default: begin
               state_r <= C_RUN;
            end
         endcase
      end
   end

   // Termination held off until lock delay
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         odt_r <= 1'b0;
      end else begin
         odt_r <= reqOdt && lockCnt_r == '0 && state_r == C_RUN;
      end
   end

   assign link.cke     = cke_r;
   assign link.csN     = pins_r[3];
   assign link.rasN    = pins_r[2];
   assign link.casN    = pins_r[1];
   assign link.weN     = pins_r[0];
   assign link.bank    = bank_r;
   assign link.addr    = addr_r;
   assign link.odt     = odt_r;
   assign reqTaken     = taken_r;
   assign lowPowerMode = state_r;

endmodule

// >>> scps_device.sv
`timescale 1ns/1ps
module scps_device (
   // System
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // Link from controller
   scps_link_if.dev                   link,
   // Status
   output logic [2:0]                 powerState,
   output logic [scps_pkg::BANKS-1:0] banksOpen,
   output logic                       allIdle,
   output logic                       odtActive,
   output logic                       selfRefreshRun,
   output logic                       illegalSeq
);

   scps_pkg::scps_pstate_t            state_r;
   scps_pkg::scps_pstate_t            state_nxt;
   scps_pkg::scps_cmd_t               cmd;
   logic                              ckePrev_r;
   logic [scps_pkg::BANKS-1:0]        bankOpen_r;
   logic [scps_pkg::CNT_W-1:0]        burstCnt_r;
   logic [scps_pkg::CNT_W-1:0]        prechgCnt_r;
   logic [scps_pkg::CNT_W-1:0]        busyCnt_r;
   logic [scps_pkg::CNT_W-1:0]        busyLoad;
   logic                              cmdLive;
   logic                              ckeFall;
   logic                              ckeRise;
   logic                              idleNow;
   logic                              illegal;
   logic                              allIdle_r;
   logic                              odtActive_r;
   logic                              selfRefreshRun_r;
   logic                              illegalSeq_r;

   // Decode pins; deselect whenever chip select is high
   always_comb begin
      if (link.csN) begin
         cmd = scps_pkg::CMD_DES;
      end else begin
         cmd = scps_pkg::scps_cmd_t'({1'b0, link.rasN, link.casN, link.weN});
      end
   end

   // Clock-enable history sampled every edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ckePrev_r <= 1'b0;
      end else begin
         ckePrev_r <= link.cke;
      end
   end

   // Commands only count with enable high at both edges
   assign cmdLive = ckePrev_r && link.cke;
   assign ckeFall = ckePrev_r && !link.cke;
   assign ckeRise = !ckePrev_r && link.cke;

   // Idle: banks closed, no burst, enable high before this edge, timers expired
   assign idleNow = (bankOpen_r == '0) && (burstCnt_r == '0) && (prechgCnt_r == '0)
                    && (busyCnt_r == '0) && ckePrev_r && (state_r == scps_pkg::PS_ON);

   // Open-bank tracking from activate and precharge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bankOpen_r <= '0;
      end else if (cmdLive) begin
         case (cmd)
            scps_pkg::CMD_ACT: begin
               bankOpen_r[link.bank] <= 1'b1;
            end
            scps_pkg::CMD_PRE: begin
               if (link.addr[scps_pkg::AP_BIT]) begin
                  bankOpen_r <= '0;
               end else begin
                  bankOpen_r[link.bank] <= 1'b0;
               end
            end
            scps_pkg::CMD_RD, scps_pkg::CMD_WR: begin
               if (link.addr[scps_pkg::AP_BIT]) begin
                  bankOpen_r[link.bank] <= 1'b0;
               end
            end
            default: begin
               bankOpen_r <= bankOpen_r;
            end
         endcase
      end
   end

   // Data burst in flight; no-op and deselect leave it running
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         burstCnt_r <= '0;
      end else if (cmdLive && (cmd == scps_pkg::CMD_RD || cmd == scps_pkg::CMD_WR)) begin
         burstCnt_r <= scps_pkg::BURST_CYCLES;
      end else begin
         burstCnt_r <= scps_pkg::decCnt(burstCnt_r);
      end
   end

   // Precharge in progress, including auto-precharge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prechgCnt_r <= '0;
      end else if (cmdLive && cmd == scps_pkg::CMD_PRE) begin
         prechgCnt_r <= scps_pkg::PRECHARGE_PERIOD;
      end else if (cmdLive && cmd == scps_pkg::CMD_WR && link.addr[scps_pkg::AP_BIT]) begin
         prechgCnt_r <= scps_pkg::AUTOPRECHARGE_WRITE_RECOVERY;
      end else if (cmdLive && cmd == scps_pkg::CMD_RD && link.addr[scps_pkg::AP_BIT]) begin
         prechgCnt_r <= scps_pkg::PRECHARGE_PERIOD;
      end else begin
         prechgCnt_r <= scps_pkg::decCnt(prechgCnt_r);
      end
   end

   // Pending timing from refresh, calibration, mode set and exits
   always_comb begin
      busyLoad = '0;
      if (cmdLive) begin
         case (cmd)
            scps_pkg::CMD_REF: busyLoad = scps_pkg::REFRESH_CYCLE_TIME;
            scps_pkg::CMD_ZQ:  busyLoad = scps_pkg::CALIBRATION_TIME;
            scps_pkg::CMD_MRS: busyLoad = scps_pkg::maxCnt(scps_pkg::MODE_SET_CMD_GAP,
                                                           scps_pkg::MODE_SET_UPDATE_DELAY);
            default:           busyLoad = '0;
         endcase
      end else if (ckeRise && state_r == scps_pkg::PS_SREF) begin
         busyLoad = scps_pkg::SELFREF_EXIT_LOCK_DELAY;
      end else if (ckeRise && state_r != scps_pkg::PS_ON) begin
         busyLoad = scps_pkg::POWERDOWN_EXIT_LOCK_DELAY;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busyCnt_r <= '0;
      end else begin
         busyCnt_r <= scps_pkg::maxCnt(scps_pkg::decCnt(busyCnt_r), busyLoad);
      end
   end

   // Power-state transitions from the enable pair and command
   always_comb begin
      state_nxt = state_r;
      illegal   = 1'b0;
      case (state_r)
         scps_pkg::PS_ON: begin
            if (ckeFall) begin
               if (cmd == scps_pkg::CMD_REF && idleNow) begin
                  state_nxt = scps_pkg::PS_SREF;
               end else if (cmd != scps_pkg::CMD_NOP && cmd != scps_pkg::CMD_DES) begin
                  illegal   = 1'b1;
                  state_nxt = scps_pkg::PS_PPD;
               end else if (burstCnt_r != '0 || prechgCnt_r != '0) begin
                  state_nxt = scps_pkg::PS_PEND;
               end else if (bankOpen_r != '0) begin
                  state_nxt = scps_pkg::PS_APD;
               end else begin
                  state_nxt = scps_pkg::PS_PPD;
               end
            end else if (!ckePrev_r && !link.cke) begin
               state_nxt = scps_pkg::PS_PPD;
            end
         end
         scps_pkg::PS_PEND: begin
            if (link.cke) begin
               state_nxt = scps_pkg::PS_ON;
            end else if (burstCnt_r == '0 && prechgCnt_r == '0) begin
               state_nxt = (bankOpen_r != '0) ? scps_pkg::PS_APD : scps_pkg::PS_PPD;
            end
         end
         scps_pkg::PS_APD, scps_pkg::PS_PPD, scps_pkg::PS_SREF: begin
            if (link.cke) begin
               state_nxt = scps_pkg::PS_ON;
               illegal   = (cmd != scps_pkg::CMD_NOP && cmd != scps_pkg::CMD_DES);
            end
         end
         default: begin
            state_nxt = scps_pkg::PS_ON;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= scps_pkg::PS_PPD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Status flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         allIdle_r        <= 1'b0;
         odtActive_r      <= 1'b0;
         selfRefreshRun_r <= 1'b0;
         illegalSeq_r     <= 1'b0;
      end else begin
         allIdle_r        <= idleNow;
         odtActive_r      <= link.odt && (state_nxt != scps_pkg::PS_SREF);
         selfRefreshRun_r <= (state_nxt == scps_pkg::PS_SREF);
         illegalSeq_r     <= illegal;
      end
   end

   assign powerState     = state_r;
   assign banksOpen      = bankOpen_r;
   assign allIdle        = allIdle_r;
   assign odtActive      = odtActive_r;
   assign selfRefreshRun = selfRefreshRun_r;
   assign illegalSeq     = illegalSeq_r;

endmodule

// >>> scps_link_asserts.sv
`timescale 1ns/1ps
module scps_link_asserts (
   // System
   input wire logic        clk_sys,
   input wire logic        resetn,
   // Link pins
   input wire logic        cke,
   input wire logic        csN,
   input wire logic        rasN,
   input wire logic        casN,
   input wire logic        weN,
   input wire logic [2:0]  bank,
   input wire logic [13:0] addr,
   input wire logic        odt
);
   localparam logic [9:0] MRS_HOLD = (scps_pkg::MODE_SET_UPDATE_DELAY >
      scps_pkg::MODE_SET_CMD_GAP) ? scps_pkg::MODE_SET_UPDATE_DELAY : scps_pkg::MODE_SET_CMD_GAP;
   logic [3:0] cmd;
   logic       quiet;
   logic       ckePrev_r;
   logic       selfRef_r;
   logic [9:0] exitCnt_r;
   logic [9:0] lockCnt_r;
   logic [9:0] wrCnt_r;
   logic [9:0] mrsCnt_r;
   logic [9:0] burstCnt_r;
   logic [7:0] open_r;

   // Command decode
   assign cmd   = {csN, rasN, casN, weN};
   assign quiet = csN || (cmd == 4'h7);

   // Self-refresh tracking and exit windows
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ckePrev_r <= 1'b1;
         selfRef_r <= 1'b0;
         exitCnt_r <= 10'h000;
         lockCnt_r <= 10'h000;
         wrCnt_r   <= 10'h000;
      end else begin
         ckePrev_r <= cke;
         if (ckePrev_r && !cke && cmd == 4'h1) begin
            selfRef_r <= 1'b1;
         end else if (cke) begin
            selfRef_r <= 1'b0;
         end
         if (selfRef_r && cke) begin
            exitCnt_r <= scps_pkg::SELFREF_EXIT_DELAY - 10'h001;
            lockCnt_r <= scps_pkg::SELFREF_EXIT_LOCK_DELAY - 10'h001;
            wrCnt_r   <= scps_pkg::SELFREF_WRITE_HOLDOFF - 10'h001;
         end else begin
            exitCnt_r <= (exitCnt_r != 10'h000) ? exitCnt_r - 10'h001 : 10'h000;
            lockCnt_r <= (lockCnt_r != 10'h000) ? lockCnt_r - 10'h001 : 10'h000;
            wrCnt_r   <= (wrCnt_r != 10'h000) ? wrCnt_r - 10'h001 : 10'h000;
         end
      end
   end

   // Mode-set gap, burst and open-bank tracking
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mrsCnt_r   <= 10'h000;
         burstCnt_r <= 10'h000;
         open_r     <= 8'h00;
      end else begin
         mrsCnt_r   <= (mrsCnt_r != 10'h000) ? mrsCnt_r - 10'h001 : 10'h000;
         burstCnt_r <= (burstCnt_r != 10'h000) ? burstCnt_r - 10'h001 : 10'h000;
         if (cke && ckePrev_r) begin
            case (cmd)
               4'h0: mrsCnt_r <= MRS_HOLD - 10'h001;
               4'h3: open_r[bank] <= 1'b1;
               4'h2: begin
                  if (addr[10]) open_r <= 8'h00;
                  else open_r[bank] <= 1'b0;
               end
               4'h4, 4'h5: begin
                  burstCnt_r <= scps_pkg::BURST_CYCLES - 10'h001;
                  if (addr[10]) open_r[bank] <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   chk_pd_edge_cmd: assert property ($fell(cke) |-> quiet || cmd == 4'h1)
      else $error("Command not NOP or DES at clock-enable fall");
   chk_exit_edge_cmd: assert property ($rose(cke) |-> quiet)
      else $error("Command not NOP or DES at clock-enable rise");
   chk_cke_min_hold: assert property ($changed(cke) |=> $stable(cke))
      else $error("Clock enable changed before minimum pulse");
   chk_srx_quiet_window: assert property (exitCnt_r != 10'h000 |-> quiet)
      else $error("Command issued inside self-refresh exit delay");
   chk_rd_lock_wait: assert property (cke && cmd == 4'h5 |-> lockCnt_r == 10'h000)
      else $error("Read issued before lock delay");
   chk_odt_lock_wait: assert property ($rose(odt) |-> lockCnt_r == 10'h000)
      else $error("Termination raised before lock delay");
   chk_wr_holdoff: assert property (cke && cmd == 4'h4 |-> wrCnt_r == 10'h000)
      else $error("Write issued before holdoff ended");
   chk_sre_when_idle: assert property ($fell(cke) && cmd == 4'h1 |->
      open_r == 8'h00 && burstCnt_r == 10'h000)
      else $error("Self-refresh entry with open bank or burst");
   chk_mrs_entry_gap: assert property ($fell(cke) |-> mrsCnt_r == 10'h000)
      else $error("Clock enable low too soon after mode set");

   cov_pd_entry: cover property ($fell(cke) && quiet);
   cov_sr_entry: cover property ($fell(cke) && cmd == 4'h1);
   cov_odt_rise: cover property ($rose(odt));
endmodule

// >>> scps_link_if.sv
`timescale 1ns/1ps
interface scps_link_if;
   logic        cke;
   logic        csN;
   logic        rasN;
   logic        casN;
   logic        weN;
   logic [2:0]  bank;
   logic [13:0] addr;
   logic        odt;

   // Memory controller end
   modport ctrl (output cke, csN, rasN, casN, weN, bank, addr, odt);
   // Memory device end
   modport dev (input cke, csN, rasN, casN, weN, bank, addr, odt);
endinterface

// >>> scps_pkg.sv
package scps_pkg;

   // Command codes as {csN, rasN, casN, weN}
   typedef enum logic [3:0] {
      CMD_MRS = 4'h0,
      CMD_REF = 4'h1,
      CMD_PRE = 4'h2,
      CMD_ACT = 4'h3,
      CMD_WR  = 4'h4,
      CMD_RD  = 4'h5,
      CMD_ZQ  = 4'h6,
      CMD_NOP = 4'h7,
      CMD_DES = 4'h8
   } scps_cmd_t;

   // Device power states
   typedef enum logic [2:0] {
      PS_ON   = 3'b000,
      PS_APD  = 3'b001,
      PS_PPD  = 3'b010,
      PS_SREF = 3'b011,
      PS_PEND = 3'b100
   } scps_pstate_t;

   // Widths
   localparam int BANKS   = 8;
   localparam int CNT_W   = 10;
   localparam int AP_BIT  = 10;

   // Timing counts in clock cycles (nCK)
   localparam logic [9:0] MODE_SET_CMD_GAP          = 10'h004;
   localparam logic [9:0] MODE_SET_UPDATE_DELAY     = 10'h00C;
   localparam logic [9:0] CKE_MIN_PULSE_TIME        = 10'h003;
   localparam logic [9:0] POWERDOWN_EXIT_DELAY      = 10'h003;
   localparam logic [9:0] POWERDOWN_EXIT_LOCK_DELAY = 10'h00A;
   localparam logic [9:0] SELFREF_EXIT_DELAY        = 10'h018;
   localparam logic [9:0] SELFREF_EXIT_LOCK_DELAY   = 10'h200;
   localparam logic [9:0] SELFREF_WRITE_HOLDOFF     = 10'h200;
   localparam logic [9:0] REFRESH_CYCLE_TIME        = 10'h010;
   localparam logic [9:0] PRECHARGE_PERIOD          = 10'h004;
   localparam logic [9:0] AUTOPRECHARGE_WRITE_RECOVERY = 10'h008;
   localparam logic [9:0] CALIBRATION_TIME          = 10'h040;
   localparam logic [9:0] BURST_CYCLES              = 10'h004;

   // Larger of two counts
   function automatic logic [9:0] maxCnt(input logic [9:0] a, input logic [9:0] b);
      maxCnt = (a > b) ? a : b;
   endfunction

   // Decrement saturating at zero
   function automatic logic [9:0] decCnt(input logic [9:0] a);
      decCnt = (a != 10'h000) ? a - 10'h001 : 10'h000;
   endfunction

endpackage

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk_sys, resetn, reqValid, reqOdt, pdReq, srReq, reqTaken;
   logic [3:0]  reqCmd;
   logic [2:0]  reqBank, powerState, fPower;
   logic [13:0] reqAddr;
   logic [1:0]  lowPowerMode;
   logic [7:0]  banksOpen, fBanks;
   logic        allIdle, odtActive, selfRefreshRun, illegalSeq, fIllegal;
   int          n_mismatch, n_checks, cycles, w;

   scps_link_if link ();
   scps_link_if linkF ();
   scps_controller scps_controller_i (.clk_sys(clk_sys), .resetn(resetn), .link(link),
      .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
      .reqOdt(reqOdt), .pdReq(pdReq), .srReq(srReq), .reqTaken(reqTaken),
      .lowPowerMode(lowPowerMode));
   scps_device scps_device_i (.clk_sys(clk_sys), .resetn(resetn), .link(link),
      .powerState(powerState), .banksOpen(banksOpen), .allIdle(allIdle),
      .odtActive(odtActive), .selfRefreshRun(selfRefreshRun), .illegalSeq(illegalSeq));
   scps_device scps_device_i2 (.clk_sys(clk_sys), .resetn(resetn), .link(linkF),
      .powerState(fPower), .banksOpen(fBanks), .allIdle(), .odtActive(),
      .selfRefreshRun(), .illegalSeq(fIllegal));
   scps_link_asserts scps_link_asserts_i (.clk_sys(clk_sys), .resetn(resetn),
      .cke(link.cke), .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
      .bank(link.bank), .addr(link.addr), .odt(link.odt));

   // Clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (resetn) check("legal", 16'(illegalSeq), 16'h0000);
      if (cycles == 8000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One-cycle request pulses, retried until taken
   task automatic req(input logic [3:0] c, input logic [13:0] a, output int waited);
      waited = 0;
      reqCmd <= c;
      reqBank <= 3'h2;
      reqAddr <= a;
      do begin
         @(posedge clk_sys);
         reqValid <= 1'b1;
         @(posedge clk_sys);
         reqValid <= 1'b0;
         #1;
         waited += 2;
      end while (reqTaken !== 1'b1 && waited < 1200);
      check("pins", 16'({link.csN, link.rasN, link.casN, link.weN}), 16'(c));
   endtask

   // Direct drive of the second link
   task automatic fdrv(input logic k, input logic [3:0] c);
      @(posedge clk_sys);
      linkF.cke <= k;
      {linkF.csN, linkF.rasN, linkF.casN, linkF.weN} <= c;
   endtask

   initial begin
      logic [2:0] expPd [3];
      logic [3:0] bad [3];
      expPd = '{scps_pkg::PS_APD, scps_pkg::PS_APD, scps_pkg::PS_PPD};
      bad = '{4'h7, 4'h8, 4'h5};
      resetn = 1'b0;
      {reqValid, reqOdt, pdReq, srReq} = 4'h0;
      reqCmd = 4'h7;
      reqBank = 3'h0;
      reqAddr = 14'h0000;
      linkF.cke = 1'b1;
      {linkF.csN, linkF.rasN, linkF.casN, linkF.weN} = 4'h7;
      linkF.bank = 3'h2;
      linkF.addr = 14'h0000;
      linkF.odt = 1'b0;
      cyc(8);
      resetn <= 1'b1;
      cyc(2);
      #1 check("state", 16'(powerState), 16'(scps_pkg::PS_ON));
      check("idle early", 16'(allIdle), 16'h0000);
      cyc(int'(scps_pkg::POWERDOWN_EXIT_LOCK_DELAY));
      #1 check("idle", 16'(allIdle), 16'h0001);
      $display("Test reset done");
      // Power-down flavour after open bank, read, read with auto-precharge
      for (int k = 0; k < 3; k++) begin
         req(4'h3, 14'h0000, w);
         if (k > 0) req(4'h5, (k == 2) ? 14'h0400 : 14'h0000, w);
         pdReq <= 1'b1;
         cyc(16);
         #1 check("pd state", 16'(powerState), 16'(expPd[k]));
         check("pd mode", 16'(lowPowerMode), 16'h0001);
         check("pd refresh", 16'(selfRefreshRun), 16'h0000);
         check("pd banks", 16'(banksOpen), (k == 2) ? 16'h0000 : 16'h0004);
         pdReq <= 1'b0;
         cyc(6);
         #1 check("pd exit", 16'(powerState), 16'(scps_pkg::PS_ON));
         req(4'h2, 14'h0400, w);
         cyc(8);
      end
      // Mode set then power-down request
      req(4'h0, 14'h0000, w);
      pdReq <= 1'b1;
      w = 0;
      while (link.cke !== 1'b0 && w < 40) begin
         cyc(1);
         w++;
      end
      check("mrs gap", 16'(w >= 11 && w < 40), 16'h0001);
      pdReq <= 1'b0;
      cyc(10);
      $display("Test power-down done");
      // Self-refresh, then first write and first read after exit
      for (int k = 0; k < 2; k++) begin
         reqOdt <= 1'b1;
         srReq <= 1'b1;
         cyc(8);
         #1 check("sr state", 16'(powerState), 16'(scps_pkg::PS_SREF));
         check("sr run", 16'(selfRefreshRun), 16'h0001);
         check("sr odt", 16'(odtActive), 16'h0000);
         check("sr mode", 16'(lowPowerMode), 16'h0002);
         srReq <= 1'b0;
         reqOdt <= 1'b0;
         w = 0;
         while (link.cke !== 1'b1 && w < 20) begin
            cyc(1);
            w++;
         end
         req((k == 0) ? 4'h4 : 4'h5, 14'h0000, w);
         check("lock wait", 16'(w >= 500 && w <= 520), 16'h0001);
         reqOdt <= 1'b1;
         cyc(3);
         #1 check("odt on", 16'(odtActive), 16'h0001);
         reqOdt <= 1'b0;
         cyc(8);
      end
      $display("Test self-refresh done");
      // Second link: edge commands, ignored pins while low
      for (int k = 0; k < 3; k++) begin
         fdrv(1'b0, bad[k]);
         fdrv(1'b0, 4'h3);
         #1 check("fall flag", 16'(fIllegal), 16'(k == 2));
         fdrv(1'b0, 4'h3);
         fdrv(1'b0, 4'h3);
         #1 check("low state", 16'(fPower), 16'(scps_pkg::PS_PPD));
         check("low banks", 16'(fBanks), 16'h0000);
         fdrv(1'b1, bad[k]);
         fdrv(1'b1, 4'h7);
         #1 check("rise flag", 16'(fIllegal), 16'(k == 2));
         check("rise state", 16'(fPower), 16'(scps_pkg::PS_ON));
         cyc(8);
      end
      $display("Test fault link done");
      give_verdict();
   end
endmodule
